// ===== watchdog_config_regs.sv
`timescale 1ns/1ps
`include "wdt_defines.svh"

module watchdog_config_regs
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire wdt_pkg::wdt_cfg_s fuse_watchdog_config,
  input wire logic watchdog_tick_clock,
  input wire logic watchdog_refresh_instr,
  input wire logic debug_mode,
  output logic sys_reset_req,
  output logic irq
);
  import wdt_pkg::*;

  boot_e boot, next_boot;
  wdt_cfg_s watchdog_control, next_watchdog_control;
  logic lock, next_lock;
  logic domain_sync_pending, next_domain_sync_pending;
  logic [2:0] guard_cnt, next_guard_cnt;
  logic [`EVT_WIDTH-1:0] event_st, next_event_st;
  logic [`EVT_WIDTH-1:0] event_mask, next_event_mask;
  logic rd_valid, next_rd_valid;
  logic [31:0] next_readdata;
  logic next_irq;
  logic [31:0] rd_mux;
  logic [2:0] idx;
  logic [7:0] wdat;
  logic wr_ok, guard_open, cfg_load, cfg_now, cfg_done;
  logic [`EVT_WIDTH-1:0] evt_set, evt_clr;
  wdt_evt_s core_evt;

  // ==========================================
  // bus decode
  always_comb
  begin
    idx = address[4:2];
    wdat = writedata[7:0];
    // reads wait one cycle so read data come from a flip-flop
    waitrequest = (boot != BOOT_RUN) | (read & ~rd_valid);
    wr_ok = write & ~waitrequest & byteenable[0];
    guard_open = (guard_cnt != 3'h0);
  end

  // ==========================================
  // boot load, control and lock
  always_comb
  begin
    next_boot = boot;
    next_watchdog_control = watchdog_control;
    next_lock = lock;
    cfg_load = 1'b0;
    cfg_now = 1'b0;
    case (boot)
      BOOT_LOAD:
      begin
        // fuse sampled by a clocked step after reset release
        next_watchdog_control = fuse_watchdog_config;
        next_lock = (fuse_watchdog_config.period != `SEL_OFF);
        cfg_now = 1'b1;
        next_boot = BOOT_RUN;
      end
      BOOT_RUN:
      begin
        // writes while busy are dropped instead of corrupting a transfer
        if (wr_ok && idx == `REG_CONTROL_IDX && guard_open && !lock
            && !domain_sync_pending)
        begin
          next_watchdog_control = wdat;
          cfg_load = 1'b1;
        end
        if (wr_ok && idx == `REG_STATUS_IDX && guard_open)
        begin
          if (wdat[`STATUS_LOCK_BIT])
            next_lock = 1'b1;
          else if (debug_mode)
            next_lock = 1'b0;
        end
      end
      default:
        next_boot = BOOT_LOAD;
    endcase
  end

  // ==========================================
  // change guard window and sync flag
  always_comb
  begin
    next_guard_cnt = guard_cnt;
    if (wr_ok && idx == `REG_GUARD_IDX && wdat == `UNLOCK_KEY)
      next_guard_cnt = `GUARD_WINDOW;
    else if (guard_open)
      next_guard_cnt = guard_cnt - 3'h1;
    // sync flag is hardware-owned; guard plays no part
    next_domain_sync_pending = domain_sync_pending;
    if (cfg_load)
      next_domain_sync_pending = 1'b1;
    else if (cfg_done)
      next_domain_sync_pending = 1'b0;
  end

  // ==========================================
  // event flags, mask and interrupt
  always_comb
  begin
    evt_set = '0;
    evt_set[`EVT_TIMEOUT_BIT] = core_evt.timeout;
    evt_set[`EVT_EARLY_BIT] = core_evt.early;
    evt_set[`EVT_SYNC_BIT] = cfg_done;
    evt_clr = '0;
    if (wr_ok && idx == `REG_EVENT_IDX)
      evt_clr = wdat[`EVT_WIDTH-1:0];
    // set beats clear so a same-cycle event is kept
    next_event_st = (event_st & ~evt_clr) | evt_set;
    next_event_mask = event_mask;
    if (wr_ok && idx == `REG_MASK_IDX)
      next_event_mask = wdat[`EVT_WIDTH-1:0];
    next_irq = |(next_event_st & next_event_mask);
  end

  // ==========================================
  // read path
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `REG_CONTROL_IDX:
        rd_mux[7:0] = watchdog_control;
      `REG_STATUS_IDX:
      begin
        rd_mux[`STATUS_LOCK_BIT] = lock;
        rd_mux[`STATUS_SYNC_BIT] = domain_sync_pending;
      end
      `REG_GUARD_IDX:
        rd_mux[0] = guard_open;
      `REG_EVENT_IDX:
        rd_mux[`EVT_WIDTH-1:0] = event_st;
      `REG_MASK_IDX:
        rd_mux[`EVT_WIDTH-1:0] = event_mask;
      default:
        rd_mux = 32'h0000_0000;
    endcase
    next_rd_valid = read & ~rd_valid & (boot == BOOT_RUN);
    next_readdata = next_rd_valid ? rd_mux : readdata;
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot <= BOOT_LOAD;
      watchdog_control <= '0;
      lock <= 1'b0;
      domain_sync_pending <= 1'b0;
      guard_cnt <= 3'h0;
      event_st <= `EVT_RESET;
      event_mask <= `MASK_RESET;
      rd_valid <= 1'b0;
      readdata <= 32'h0000_0000;
      irq <= 1'b0;
    end
    else
    begin
      boot <= next_boot;
      watchdog_control <= next_watchdog_control;
      lock <= next_lock;
      domain_sync_pending <= next_domain_sync_pending;
      guard_cnt <= next_guard_cnt;
      event_st <= next_event_st;
      event_mask <= next_event_mask;
      rd_valid <= next_rd_valid;
      readdata <= next_readdata;
      irq <= next_irq;
    end
  end

  // ==========================================
  // watchdog counter on tick edges
  wdt_tick_core u_core
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .watchdog_tick_clock(watchdog_tick_clock),
    .debug_mode(debug_mode),
    .watchdog_refresh_instr(watchdog_refresh_instr),
    .cfg_load(cfg_load),
    .cfg_now(cfg_now),
    .cfg_in(next_watchdog_control),
    .cfg_done(cfg_done),
    .evt(core_evt),
    .sys_reset_req(sys_reset_req)
  );

  // ==========================================
  // checks
  lock_clear_debug_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(lock) |-> $past(debug_mode) && $past(guard_open))
    else $error("lock cleared outside debug mode");
  control_locked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(lock) && $past(boot) == BOOT_RUN) |-> $stable(watchdog_control))
    else $error("control changed while locked");
  control_guarded_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ($past(boot) == BOOT_RUN && !$stable(watchdog_control)) |-> $past(guard_open))
    else $error("control changed without unlock key");
  sync_flag_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ok && idx == `REG_CONTROL_IDX && guard_open && !lock && !domain_sync_pending
     && boot == BOOT_RUN) |=> domain_sync_pending [*2])
    else $error("sync flag not held after control write");
  boot_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (boot == BOOT_LOAD) |=> (lock == (fuse_watchdog_config.period != `SEL_OFF)
                             ## 0 watchdog_control == $past(fuse_watchdog_config)))
    else $error("boot load of fuse or lock wrong");
  guard_expiry_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (guard_cnt == `GUARD_WINDOW) |-> ##4 (guard_cnt == 3'h0 || $past(wr_ok)))
    else $error("unlock window longer than four cycles");
  irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 (irq == |(event_st & event_mask)))
    else $error("interrupt does not follow masked flags");
  read_answer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (read && boot == BOOT_RUN && !rd_valid) |=> (!waitrequest ##1 !rd_valid))
    else $error("read not answered after one wait cycle");

endmodule

// ===== watchdog_config_regs_tb_top.sv
`timescale 1ns/1ps
module watchdog_config_regs_tb_top;
  import wdt_pkg::*;
  // ==========================================
  // stimulus and observation
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  wdt_cfg_s fuse = 8'h00;
  logic tick = 1'b0;
  logic refresh = 1'b0;
  logic debug_mode = 1'b0;
  logic sys_reset_req;
  logic irq;
  logic chk_on = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] lfsr = 32'h852A;
  logic [2:0] tick_div = 3'h0;
  int miscompares = 0;
  int checked = 0;
  int pulses = 0;
  always #2.5 mclk = ~mclk;
  watchdog_config_regs u_watchdog_config_regs (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .fuse_watchdog_config(fuse), .watchdog_tick_clock(tick),
    .watchdog_refresh_instr(refresh), .debug_mode(debug_mode), .sys_reset_req(sys_reset_req), .irq(irq));
  // one tick every 8 mclk cycles, kept short so timeouts fit the run
  always @(posedge mclk)
  begin
    tick_div <= tick_div + 3'h1;
    if (tick_div[1:0] == 2'h3)
      tick <= ~tick;
    if (sys_reset_req === 1'b1)
      pulses <= pulses + 1;
  end
  // ==========================================
  // checking
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(posedge mclk)
    if (read && waitrequest === 1'b0 && chk_on)
    begin
      if (exp_q.size() == 0)
        check("queue", 32'h1, 32'h0);
      else
        check("readdata", readdata, exp_q.pop_front());
    end
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic report_and_stop;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
  // ==========================================
  // bus tasks
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    @(posedge mclk);
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] idx, input logic c, output logic [31:0] d);
    @(posedge mclk);
    address <= {idx, 2'b00};
    read <= 1'b1;
    chk_on <= c;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    chk_on <= 1'b0;
  endtask
  task automatic expect_rd(input logic [2:0] idx, input logic [7:0] e);
    logic [31:0] d;
    exp_q.push_back({24'h0, e});
    rd(idx, 1'b1, d);
  endtask
  task automatic guarded_wr(input logic [2:0] idx, input logic [7:0] d);
    wr(3'h2, `UNLOCK_KEY);
    wr(idx, d);
  endtask
  task automatic wait_sync;
    logic [31:0] d;
    for (int i = 0; i < 60; i++)
    begin
      rd(3'h1, 1'b0, d);
      if (d[`STATUS_SYNC_BIT] === 1'b0)
        break;
    end
  endtask
  task automatic do_refresh;
    @(posedge mclk);
    refresh <= 1'b1;
    @(posedge mclk);
    refresh <= 1'b0;
  endtask
  task automatic wait_pulse(input int bound, output int n);
    int p;
    p = pulses;
    n = 0;
    while (pulses == p && n < bound)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic do_reset(input logic [7:0] f);
    @(posedge mclk);
    rst_n <= 1'b0;
    fuse <= f;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  // ==========================================
  // scenarios
  initial
  begin
    int n;
    int p;
    do_reset(8'h00);
    expect_rd(3'h0, 8'h00);
    expect_rd(3'h1, 8'h00);
    for (int i = 5; i < 8; i++)
    begin
      lfsr = next_rand(lfsr);
      wr(i[2:0], lfsr[7:0]);
      expect_rd(i[2:0], 8'h00);
    end
    wr(3'h0, 8'h23);
    expect_rd(3'h0, 8'h00);
    wr(3'h2, `UNLOCK_KEY);
    repeat (5) @(posedge mclk);
    wr(3'h0, 8'h23);
    expect_rd(3'h0, 8'h00);
    guarded_wr(3'h0, 8'h23);
    wr(3'h0, 8'h45);
    expect_rd(3'h1, 8'h01);
    expect_rd(3'h0, 8'h23);
    wait_sync();
    expect_rd(3'h1, 8'h00);
    guarded_wr(3'h1, 8'h01);
    expect_rd(3'h1, 8'h00);
    wr(3'h1, 8'h80);
    expect_rd(3'h1, 8'h00);
    guarded_wr(3'h1, 8'h80);
    expect_rd(3'h1, 8'h80);
    guarded_wr(3'h0, 8'h00);
    expect_rd(3'h0, 8'h23);
    guarded_wr(3'h1, 8'h00);
    expect_rd(3'h1, 8'h80);
    debug_mode <= 1'b1;
    guarded_wr(3'h1, 8'h00);
    expect_rd(3'h1, 8'h00);
    debug_mode <= 1'b0;
    // shortest period: 8 ticks of 8 mclk each
    guarded_wr(3'h0, 8'h01);
    wait_sync();
    wr(3'h3, 8'h07);
    wait_pulse(200, n);
    check("timeout_in_range", (n >= 40 && n <= 90), 1'b1);
    expect_rd(3'h3, 8'h01);
    wr(3'h4, 8'h01);
    repeat (2) @(posedge mclk);
    check("irq_set", irq, 1'b1);
    // hold the counter so no fresh timeout re-sets the flag mid-check
    debug_mode <= 1'b1;
    wr(3'h3, 8'h01);
    repeat (2) @(posedge mclk);
    check("irq_clear", irq, 1'b0);
    debug_mode <= 1'b0;
    p = pulses;
    for (int i = 0; i < 12; i++)
    begin
      do_refresh();
      repeat (24) @(posedge mclk);
    end
    check("refresh_holds", pulses, p);
    // window mode: second refresh lands inside the closed part
    guarded_wr(3'h0, 8'h11);
    wait_sync();
    do_refresh();
    wr(3'h3, 8'h07);
    repeat (16) @(posedge mclk);
    p = pulses;
    do_refresh();
    wait_pulse(100, n);
    check("early_reset", pulses, p + 1);
    expect_rd(3'h3, 8'h02);
    guarded_wr(3'h0, 8'h0C);
    wait_sync();
    wr(3'h3, 8'h07);
    p = pulses;
    repeat (150) @(posedge mclk);
    check("reserved_off", pulses, p);
    do_reset(8'h35);
    expect_rd(3'h0, 8'h35);
    expect_rd(3'h1, 8'h80);
    repeat (4) @(posedge mclk);
    check("queue_empty", exp_q.size(), 32'h0);
    report_and_stop();
  end
endmodule

// ===== wdt_defines.svh
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ==========================================
// register indices (byte address = 4 * index)
`define REG_CONTROL_IDX 3'h0
`define REG_STATUS_IDX 3'h1
`define REG_GUARD_IDX 3'h2
`define REG_EVENT_IDX 3'h3
`define REG_MASK_IDX 3'h4

// ==========================================
// field positions and reset values
`define STATUS_LOCK_BIT 7
`define STATUS_SYNC_BIT 0
`define STATUS_RESET 8'h00
`define EVT_TIMEOUT_BIT 0
`define EVT_EARLY_BIT 1
`define EVT_SYNC_BIT 2
`define EVT_WIDTH 3
`define EVT_RESET 3'h0
`define MASK_RESET 3'h0

// ==========================================
// change guard
// key value is arbitrary
`define UNLOCK_KEY 8'h5A
`define GUARD_WINDOW 3'h4

// ==========================================
// selector encoding and tick counts
`define SEL_OFF 4'h0
`define SEL_MAX 4'hB
`define SEL_SHIFT_BASE 4'h2
`define CNT_W 15
`define SYNC_TICKS 2'h2
`define REFRESH_SYNC_TICKS 2'h2

`endif

// ===== wdt_pkg.sv
package wdt_pkg;

  typedef struct packed
  {
    logic [3:0] window;
    logic [3:0] period;
  } wdt_cfg_s;

  typedef struct packed
  {
    logic early;
    logic timeout;
  } wdt_evt_s;

  typedef enum logic [1:0]
  {
    BOOT_LOAD = 2'b01,
    BOOT_RUN = 2'b10
  } boot_e;

  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b001,
    PH_CLOSED = 3'b010,
    PH_OPEN = 3'b100
  } phase_e;

endpackage

// ===== wdt_tick_core.sv
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_tick_core
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic watchdog_tick_clock,
  input wire logic debug_mode,
  input wire logic watchdog_refresh_instr,
  input wire logic cfg_load,
  input wire logic cfg_now,
  input wire wdt_pkg::wdt_cfg_s cfg_in,
  output logic cfg_done,
  output wdt_pkg::wdt_evt_s evt,
  output logic sys_reset_req
);
  import wdt_pkg::*;

  // length in ticks: 8 << (code - 1); reserved or zero codes give 0 (off)
  function automatic logic [`CNT_W-1:0] sel_len(input logic [3:0] code);
    logic [`CNT_W-1:0] one;
    one = `CNT_W'(1);
    if (code == `SEL_OFF || code > `SEL_MAX)
      return '0;
    return one << (code + `SEL_SHIFT_BASE);
  endfunction

  logic tick_q, next_tick_q;
  wdt_cfg_s cfg, next_cfg, cfg_hold, next_cfg_hold;
  logic sync_busy, next_sync_busy;
  logic [1:0] sync_cnt, next_sync_cnt;
  logic ref_busy, next_ref_busy;
  logic [1:0] ref_cnt, next_ref_cnt;
  phase_e phase, next_phase;
  logic [`CNT_W-1:0] cnt, next_cnt;
  logic armed, next_armed;
  logic next_cfg_done, next_sys_reset_req;
  wdt_evt_s next_evt;
  logic tick, ref_fire, cfg_apply;
  logic [`CNT_W-1:0] open_len, closed_len;

  // ==========================================
  // next state
  always_comb
  begin
    tick = watchdog_tick_clock & ~tick_q;
    next_tick_q = watchdog_tick_clock;
    next_cfg = cfg;
    next_cfg_hold = cfg_hold;
    next_sync_busy = sync_busy;
    next_sync_cnt = sync_cnt;
    next_cfg_done = 1'b0;
    cfg_apply = 1'b0;
    // control crosses into the tick domain over two tick edges
    if (cfg_now)
    begin
      next_cfg = cfg_in;
      next_sync_busy = 1'b0;
      cfg_apply = 1'b1;
    end
    else if (cfg_load)
    begin
      next_cfg_hold = cfg_in;
      next_sync_busy = 1'b1;
      next_sync_cnt = 2'h0;
    end
    else if (sync_busy && tick)
    begin
      if (sync_cnt == `SYNC_TICKS - 2'h1)
      begin
        next_cfg = cfg_hold;
        next_sync_busy = 1'b0;
        next_cfg_done = 1'b1;
        cfg_apply = 1'b1;
      end
      else
        next_sync_cnt = sync_cnt + 2'h1;
    end
    // refresh also needs tick edges before it counts
    next_ref_busy = ref_busy;
    next_ref_cnt = ref_cnt;
    ref_fire = 1'b0;
    if (watchdog_refresh_instr)
    begin
      next_ref_busy = 1'b1;
      next_ref_cnt = 2'h0;
    end
    else if (ref_busy && tick)
    begin
      if (ref_cnt == `REFRESH_SYNC_TICKS - 2'h1)
      begin
        ref_fire = 1'b1;
        next_ref_busy = 1'b0;
      end
      else
        next_ref_cnt = ref_cnt + 2'h1;
    end
    open_len = sel_len(cfg.period);
    closed_len = sel_len(cfg.window);
    next_phase = phase;
    next_cnt = cnt;
    next_armed = armed;
    next_evt = '0;
    next_sys_reset_req = 1'b0;
    // debug halt or new config restarts; window only after first refresh
    if (debug_mode || open_len == '0 || cfg_apply)
    begin
      next_phase = PH_IDLE;
      next_cnt = '0;
      next_armed = 1'b0;
    end
    else
    begin
      case (phase)
        PH_IDLE:
        begin
          next_cnt = '0;
          next_phase = (armed && closed_len != '0) ? PH_CLOSED : PH_OPEN;
        end
        PH_CLOSED:
        begin
          if (ref_fire)
          begin
            next_evt.early = 1'b1;
            next_sys_reset_req = 1'b1;
            next_phase = PH_IDLE;
            next_armed = 1'b0;
          end
          else if (tick)
          begin
            if (cnt == closed_len - `CNT_W'(1))
            begin
              next_cnt = '0;
              next_phase = PH_OPEN;
            end
            else
              next_cnt = cnt + `CNT_W'(1);
          end
        end
        PH_OPEN:
        begin
          if (ref_fire)
          begin
            next_cnt = '0;
            next_armed = 1'b1;
            next_phase = (closed_len != '0) ? PH_CLOSED : PH_OPEN;
          end
          else if (tick)
          begin
            if (cnt == open_len - `CNT_W'(1))
            begin
              next_evt.timeout = 1'b1;
              next_sys_reset_req = 1'b1;
              next_phase = PH_IDLE;
              next_armed = 1'b0;
            end
            else
              next_cnt = cnt + `CNT_W'(1);
          end
        end
        default:
          next_phase = PH_IDLE;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_q <= 1'b0;
      cfg <= '0;
      cfg_hold <= '0;
      sync_busy <= 1'b0;
      sync_cnt <= 2'h0;
      ref_busy <= 1'b0;
      ref_cnt <= 2'h0;
      phase <= PH_IDLE;
      cnt <= '0;
      armed <= 1'b0;
      cfg_done <= 1'b0;
      evt <= '0;
      sys_reset_req <= 1'b0;
    end
    else
    begin
      tick_q <= next_tick_q;
      cfg <= next_cfg;
      cfg_hold <= next_cfg_hold;
      sync_busy <= next_sync_busy;
      sync_cnt <= next_sync_cnt;
      ref_busy <= next_ref_busy;
      ref_cnt <= next_ref_cnt;
      phase <= next_phase;
      cnt <= next_cnt;
      armed <= next_armed;
      cfg_done <= next_cfg_done;
      evt <= next_evt;
      sys_reset_req <= next_sys_reset_req;
    end
  end

  // ==========================================
  // checks
  early_refresh_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (phase == PH_CLOSED && ref_fire && !debug_mode && !cfg_apply) |=> (sys_reset_req && evt.early))
    else $error("refresh in closed window did not reset");
  timeout_length_a: assert property (@(posedge mclk) disable iff (!rst_n)
    evt.timeout |-> ($past(phase) == PH_OPEN && $past(cnt) == $past(open_len) - `CNT_W'(1)))
    else $error("timeout fired at wrong count");
  sync_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_done |-> ($past(sync_busy) && !sync_busy && cfg == $past(cfg_hold)))
    else $error("sync completion without transfer");

endmodule
